// >>> amli_cfg.svh
// Constants for the asynchronous modem line interface: offsets, bit positions,
// reset values and timing counts. Assumes a 50 MHz system clock.
// Summary of operation
// - Modem stays off line while control bit 1 clear.
// - Test mode loops transmit data into receiver.
// - Channel clear resets logic and disconnects modem.
// - Connect drops after 6 s without carrier.
// - Half duplex drops send request two bits later.
// - Bit 8 set: only deactivate, clears or connect timeout drop request.
// - Carrier error and error summary status bits.
// - Clears zero carrier error enable.
// - Control bit 10 drives frequency select.
// - Bits 11-12 choose 8,7,6,5 data bits.
// - Control bit 13 picks one or two stops.
// - Bit 14 enables even parity generate and check.
// - Bit 15 selects half duplex, carrier blocks request.
// - Output status bit 2 shows transmitter busy.
// - Output status bit 3 shows buffer can accept.
// - Output status shows send request, clear-to-send, mirrors.
// - Half duplex request waits for carrier off.
// - Output control bit 0 echoed as status.
// - Receiver flags framing error and overrun.
// - Received characters right justified.
// - Missing bits read 1 when signal absent.
`ifndef AMLI_CFG_SVH
`define AMLI_CFG_SVH

`define AMLI_CLK_HZ       50000000
`define AMLI_TIMEOUT_S    6
`define AMLI_TIMEOUT_CYC  (`AMLI_TIMEOUT_S * `AMLI_CLK_HZ)
`define AMLI_BIT_RATE     9600
`define AMLI_BIT_CYC      (`AMLI_CLK_HZ / `AMLI_BIT_RATE)
`define AMLI_REL_BITS     2

`define AMLI_A_RXDATA     3'h0
`define AMLI_A_ISTAT      3'h2
`define AMLI_A_ICTL       3'h3
`define AMLI_A_CONNECT    3'h4
`define AMLI_A_TXDATA     3'h5
`define AMLI_A_OSTAT      3'h6
`define AMLI_A_OCTL       3'h7

`define AMLI_IC_ERR_EN    1
`define AMLI_IC_ACT       2
`define AMLI_IC_TEST      3
`define AMLI_IC_CLR       4
`define AMLI_IC_TO_DIS    7
`define AMLI_IC_REL_DIS   8
`define AMLI_IC_CAR_EN    9
`define AMLI_IC_FREQ      10
`define AMLI_IC_STOP1     13
`define AMLI_IC_PAR       14
`define AMLI_IC_HALF      15
`define AMLI_OC_ACT       2
`define AMLI_OC_MASK      16'h0005
`define AMLI_CTL_RST      16'h0000

`endif

// >>> amli_pkg.sv
// Types shared by the asynchronous modem line interface.
// Assumes amli_cfg.svh is on the include path.
`include "amli_cfg.svh"

package amli_pkg;

    typedef enum logic [1:0] {
        AMLI_RX_IDLE  = 2'b00,
        AMLI_RX_START = 2'b01,
        AMLI_RX_DATA  = 2'b10,
        AMLI_RX_STOP  = 2'b11
    } amli_rx_t;

    // Complete state of the interface; synchroniser order is {cts, dsr, car, rxd}.
    typedef struct packed {
        logic [3:0]  sy0;
        logic [3:0]  sy1;
        logic [3:0]  sy2;
        logic [3:0]  filt;
        logic [15:0] ictl;
        logic [15:0] octl;
        logic        connect;
        logic        con_o;
        logic        rts;
        logic        rts_want;
        logic        sent;
        logic [28:0] to_cnt;
        logic [16:0] rel_cnt;
        logic [7:0]  hold;
        logic        hold_v;
        logic [11:0] shift;
        logic [3:0]  tx_bits;
        logic [15:0] tx_cnt;
        logic        txd;
        amli_rx_t    rx_st;
        logic [15:0] rx_cnt;
        logic [3:0]  rx_bits;
        logic [8:0]  rx_sh;
        logic [7:0]  rx_data;
        logic        rx_rdy;
        logic        fe;
        logic        pe;
        logic        ov;
        logic [15:0] rdata;
    } amli_state_t;

endpackage

// >>> amli_line_if.sv
// Asynchronous modem line interface: register port, transmitter, receiver
// and modem control. Assumes a 50 MHz clock and modem pins high when on.
`timescale 1ns/1ps
`default_nettype none
`include "amli_cfg.svh"

module amli_line_if
    import amli_pkg::*;
#(
    parameter int TIMEOUT_CYC = `AMLI_TIMEOUT_CYC,
    parameter int BIT_CYC     = `AMLI_BIT_CYC
) (
    input  wire logic        mclk_in,
    input  wire logic        rstn_in,
    input  wire logic [2:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    input  wire logic        rxd_in,
    input  wire logic        carrier_in,
    input  wire logic        dsr_in,
    input  wire logic        cts_in,
    output logic             txd_out,
    output logic             connect_out,
    output logic             rts_out,
    output logic             freq_sel_out
);

    amli_state_t r;
    amli_state_t n;

    // Character geometry shared by both channels.
    logic [3:0]  len;
    logic        par;
    logic [3:0]  nb;
    logic [7:0]  mask8;
    logic [7:0]  dm;
    logic [8:0]  pay9;
    logic        carrier;
    logic        line;
    logic        tx_idle;
    logic        rel_run;
    logic [15:0] istat;
    logic [15:0] ostat;

    assign len   = 4'h8 - {2'b00, r.ictl[12], r.ictl[11]};
    assign par   = r.ictl[`AMLI_IC_PAR];
    assign nb    = len + {3'b000, par};
    assign mask8 = 8'hFF >> {r.ictl[12], r.ictl[11]};
    assign dm    = r.hold & mask8;
    // Even parity bit sits just above the data bits.
    assign pay9  = {1'b0, dm} | ({8'h00, par & (^dm)} << len);

    assign carrier = r.filt[1];
    // Loopback taps the transmitter; the line pin keeps carrying it too.
    assign line    = r.ictl[`AMLI_IC_TEST] ? r.txd : r.filt[0];
    assign tx_idle = (r.tx_bits == 4'h0) && !r.hold_v;
    assign rel_run = r.ictl[`AMLI_IC_HALF] && !r.ictl[`AMLI_IC_REL_DIS] && r.rts
                     && r.sent && tx_idle;

    // Input status word, missing bits read 1 when the signal is absent.
    always_comb begin
        istat      = 16'h0000;
        istat[0]   = r.ictl[0];
        istat[1]   = r.ictl[1];
        istat[2]   = r.ictl[2];
        istat[3]   = r.rx_rdy;
        istat[5]   = r.fe;
        istat[6]   = r.pe;
        istat[7]   = r.ov;
        istat[8]   = !carrier && r.ictl[`AMLI_IC_CAR_EN];
        istat[4]   = |istat[8:5];
        istat[9]   = r.ictl[`AMLI_IC_CAR_EN];
        istat[10]  = r.ictl[`AMLI_IC_FREQ];
        istat[11]  = !carrier;
        istat[12]  = !r.con_o;
        istat[13]  = !r.filt[2];
        istat[15]  = r.ictl[`AMLI_IC_HALF];
    end

    // Output status word; busy covers both the shifter and the holding buffer.
    always_comb begin
        ostat      = 16'h0000;
        ostat[0]   = r.octl[0];
        ostat[2]   = (r.tx_bits != 4'h0) || r.hold_v;
        ostat[3]   = !r.hold_v;
        ostat[10]  = istat[10];
        ostat[11]  = istat[11];
        ostat[12]  = !r.rts;
        ostat[13]  = !r.filt[3];
        ostat[15]  = istat[15];
    end

    // Next-state logic for the whole interface.
    always_comb begin
        logic clr;
        amli_state_t keep;
        clr  = 1'b0;
        keep = r;
        n    = r;

        // Pins pass three stages; a level is accepted once stages two and three agree.
        n.sy0  = {cts_in, dsr_in, carrier_in, rxd_in};
        n.sy1  = r.sy0;
        n.sy2  = r.sy1;
        n.filt = (r.filt & (r.sy1 ^ r.sy2)) | (r.sy2 & ~(r.sy1 ^ r.sy2));

        // Read data stands for exactly one cycle after the strobe.
        n.rdata = 16'h0000;
        if (rd_in) begin
            if (addr_in == `AMLI_A_RXDATA) begin
                n.rdata  = {8'h00, r.rx_data};
                n.rx_rdy = 1'b0;
                n.ov     = 1'b0;
            end else if (addr_in == `AMLI_A_ISTAT) begin
                n.rdata = istat;
            end else if (addr_in == `AMLI_A_OSTAT) begin
                n.rdata = ostat;
            end else begin
                n.rdata = 16'h0000;
            end
        end

        // Register writes.
        if (wr_in) begin
            if (addr_in == `AMLI_A_ICTL) begin
                if (wdata_in[`AMLI_IC_CLR]) begin
                    clr = 1'b1;
                end else begin
                    n.ictl = wdata_in;
                    n.ictl[`AMLI_IC_CLR] = 1'b0;
                    if (wdata_in[`AMLI_IC_ACT] && !r.ictl[`AMLI_IC_ACT]) begin
                        n.connect = 1'b1;
                        n.to_cnt  = 29'h0;
                    end else if (!wdata_in[`AMLI_IC_ACT]) begin
                        n.connect = 1'b0;
                    end
                end
            end else if (addr_in == `AMLI_A_CONNECT) begin
                n.connect = 1'b1;
                n.to_cnt  = 29'h0;
            end else if (addr_in == `AMLI_A_OCTL) begin
                n.octl = wdata_in & `AMLI_OC_MASK;
                if (wdata_in[`AMLI_OC_ACT]) begin
                    n.rts_want = 1'b1;
                end else begin
                    n.rts      = 1'b0;
                    n.rts_want = 1'b0;
                    n.connect  = 1'b0;
                end
            end else if (addr_in == `AMLI_A_TXDATA) begin
                // A write into a full buffer is dropped; software polls ready first.
                if (!r.hold_v) begin
                    n.hold     = wdata_in[7:0] & mask8;
                    n.hold_v   = 1'b1;
                    n.rts_want = r.octl[`AMLI_OC_ACT];
                end
            end
        end

        // Connect timeout runs only while carrier is absent.
        if (r.connect && !carrier && !r.ictl[`AMLI_IC_TO_DIS]) begin
            n.to_cnt = r.to_cnt + 29'h1;
            if (r.to_cnt == 29'(TIMEOUT_CYC - 1)) begin
                n.connect = 1'b0;
                n.to_cnt  = 29'h0;
            end
        end else if (carrier) begin
            n.to_cnt = 29'h0;
        end

        // Transmitter: load the shifter from the buffer, then clock bits out.
        if (r.tx_bits == 4'h0) begin
            if (r.hold_v && r.octl[`AMLI_OC_ACT] && r.rts) begin
                n.shift   = ({2'b00, pay9, 1'b0}) | (12'hFFF << (nb + 4'h1));
                n.tx_bits = 4'h1 + nb + (r.ictl[`AMLI_IC_STOP1] ? 4'h1 : 4'h2);
                n.tx_cnt  = 16'h0;
                n.hold_v  = 1'b0;
                n.sent    = 1'b0;
            end
        end else if (r.tx_cnt == 16'(BIT_CYC - 1)) begin
            n.tx_cnt  = 16'h0;
            n.shift   = {1'b1, r.shift[11:1]};
            n.tx_bits = r.tx_bits - 4'h1;
            n.sent    = (r.tx_bits == 4'h1);
        end else begin
            n.tx_cnt = r.tx_cnt + 16'h1;
        end
        n.txd = (n.tx_bits != 4'h0) ? n.shift[0] : 1'b1;

        // Half duplex send request: raised only while carrier is off.
        if (rel_run) begin
            n.rel_cnt = r.rel_cnt + 17'h1;
            if (r.rel_cnt == 17'(`AMLI_REL_BITS * BIT_CYC - 1)) begin
                n.rts      = 1'b0;
                n.rts_want = 1'b0;
                n.sent     = 1'b0;
                n.rel_cnt  = 17'h0;
            end
        end else begin
            n.rel_cnt = 17'h0;
        end
        if (n.rts_want && !r.rts && !carrier && n.connect) begin
            n.rts = 1'b1;
        end

        // Receiver, gated by input activate.
        case (r.rx_st)
            AMLI_RX_IDLE: begin
                n.rx_cnt = 16'h0;
                if (r.ictl[`AMLI_IC_ACT] && !line) begin
                    n.rx_st = AMLI_RX_START;
                end
            end
            AMLI_RX_START: begin
                n.rx_cnt = r.rx_cnt + 16'h1;
                if (r.rx_cnt == 16'(BIT_CYC / 2)) begin
                    n.rx_cnt  = 16'h0;
                    n.rx_bits = 4'h0;
                    n.rx_sh   = 9'h000;
                    n.rx_st   = line ? AMLI_RX_IDLE : AMLI_RX_DATA;
                end
            end
            AMLI_RX_DATA: begin
                n.rx_cnt = r.rx_cnt + 16'h1;
                if (r.rx_cnt == 16'(BIT_CYC - 1)) begin
                    n.rx_cnt            = 16'h0;
                    n.rx_sh[r.rx_bits]  = line;
                    n.rx_bits           = r.rx_bits + 4'h1;
                    if (r.rx_bits == nb - 4'h1) begin
                        n.rx_st = AMLI_RX_STOP;
                    end
                end
            end
            AMLI_RX_STOP: begin
                n.rx_cnt = r.rx_cnt + 16'h1;
                if (r.rx_cnt == 16'(BIT_CYC - 1)) begin
                    // A new character wins over a same-cycle read of the old one.
                    n.ov      = r.rx_rdy && r.ictl[`AMLI_IC_ACT];
                    n.fe      = !line;
                    n.pe      = par && (^(r.rx_sh & (9'h1FF >> (4'h9 - nb))));
                    n.rx_data = r.rx_sh[7:0] & mask8;
                    n.rx_rdy  = 1'b1;
                    n.rx_st   = AMLI_RX_IDLE;
                end
            end
            default: begin
                n.rx_st = AMLI_RX_IDLE;
            end
        endcase

        // Full duplex ties the send request to connect.
        if (!n.ictl[`AMLI_IC_HALF]) begin
            n.rts = n.connect;
        end else if (!n.rts_want) begin
            // A request left over from full duplex must not outlive the mode change.
            n.rts = 1'b0;
        end
        if (!n.connect) begin
            n.rts = 1'b0;
        end

        // Both clears zero all control, including bits 7, 8, 9, 10 and 15.
        if (!rstn_in || clr) begin
            n      = '0;
            n.txd  = 1'b1;
            if (clr) begin
                n.sy0  = keep.sy0;
                n.sy1  = keep.sy1;
                n.sy2  = keep.sy2;
                n.filt = keep.filt;
            end
        end
        n.con_o = n.connect && n.ictl[`AMLI_IC_ERR_EN];
    end

    // Single state register.
    always_ff @(posedge mclk_in) begin
        r <= n;
    end

    assign rdata_out    = r.rdata;
    assign txd_out      = r.txd;
    assign connect_out  = r.con_o;
    assign rts_out      = r.rts;
    assign freq_sel_out = r.ictl[`AMLI_IC_FREQ];

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);

    chk_connect_gate: assert property (r.con_o |-> r.ictl[1] && r.connect)
        else $error("connect driven with control bit 1 clear");

    chk_loop_start: assert property (r.ictl[3] && r.ictl[2] && !r.txd &&
        r.rx_st == AMLI_RX_IDLE |=> r.rx_st == AMLI_RX_START)
        else $error("loopback start bit not seen by receiver");

    chk_clear_zero: assert property (wr_in && addr_in == `AMLI_A_ICTL && wdata_in[4]
        |=> r.ictl == `AMLI_CTL_RST && !connect_out && !rts_out)
        else $error("channel clear left control or connect set");

    chk_timeout_drop: assert property (r.connect && !carrier && !r.ictl[7] && !wr_in &&
        r.to_cnt == 29'(TIMEOUT_CYC - 1) |=> !r.connect)
        else $error("connect not dropped at timeout");

    chk_rts_release: assert property (rel_run && !wr_in &&
        r.rel_cnt == 17'(`AMLI_REL_BITS * BIT_CYC - 1) |=> !rts_out)
        else $error("send request not released after two bits");

    chk_rts_drop: assert property (wr_in && addr_in == `AMLI_A_OCTL && !wdata_in[2]
        |=> !rts_out && !connect_out)
        else $error("deactivate did not drop request and connect");

    chk_err_sum: assert property (rd_in && addr_in == `AMLI_A_ISTAT |=>
        rdata_out[4] == (|rdata_out[8:5]) && rdata_out[8] == (rdata_out[11] & rdata_out[9]))
        else $error("error summary status wrong");

    chk_full_dup: assert property (!r.ictl[15] |-> rts_out == r.connect)
        else $error("full duplex request differs from connect");

    chk_ready_busy: assert property (rd_in && addr_in == `AMLI_A_OSTAT |=>
        (rdata_out[3] || rdata_out[2]) && rdata_out[12] == !$past(rts_out))
        else $error("output status ready or request wrong");

    chk_frame_bits: assert property (r.tx_bits == 4'h0 && $past(r.tx_bits) == 4'h0 &&
        r.hold_v && r.octl[2] && r.rts |=> r.tx_bits == 4'h1 + nb +
        (r.ictl[13] ? 4'h1 : 4'h2))
        else $error("frame length wrong");

    cov_tx_start: cover property (r.tx_bits == 4'h0 ##1 r.tx_bits != 4'h0);
    cov_rx_done:  cover property (r.rx_st == AMLI_RX_STOP ##1 r.rx_rdy);
    cov_timeout:  cover property (r.connect ##1 !r.connect && !wr_in);
    cov_release:  cover property (rel_run ##1 !rts_out);

endmodule

`default_nettype wire

// >>> amli_modem_model.sv
// Line modem model standing on the far side of the modem line interface.
// Assumes one shared clock; the bench sets carrier and calls send_frame.
`timescale 1ns/1ps
`default_nettype none

module amli_modem_model #(
    parameter int BIT_CYC = 8
) (
    input  wire logic mclk_in,
    input  wire logic carrier_on_in,
    input  wire logic connect_in,
    input  wire logic rts_in,
    output logic      carrier_out,
    output logic      dsr_out,
    output logic      cts_out,
    output logic      rxd_out
);
    // Ready signals answer the interface one cycle late, as a slow modem would.
    always_ff @(posedge mclk_in) begin
        dsr_out     <= connect_in;
        cts_out     <= rts_in;
        carrier_out <= carrier_on_in;
    end

    // The receive line idles at the marking level.
    initial rxd_out = 1'b1;

    // One start bit, n bits LSB first, one stop level, then idle marking.
    task automatic send_frame(input logic [11:0] bits, input int n, input logic stop);
        @(posedge mclk_in);
        rxd_out <= 1'b0;
        repeat (BIT_CYC) @(posedge mclk_in);
        for (int i = 0; i < n; i++) begin
            rxd_out <= bits[i];
            repeat (BIT_CYC) @(posedge mclk_in);
        end
        rxd_out <= stop;
        repeat (BIT_CYC) @(posedge mclk_in);
        rxd_out <= 1'b1;
        repeat (2 * BIT_CYC) @(posedge mclk_in);
    endtask
endmodule
`default_nettype wire

// >>> tb_async_modem_line_interface.sv
// Self-checking bench for the modem line interface: registers, frames, modem.
// Assumes amli_modem_model and shortened bit and timeout counts.
`timescale 1ns/1ps
`default_nettype none
`include "amli_cfg.svh"

module tb_async_modem_line_interface;
    localparam int BC = 8;
    localparam int TO = 200;
    localparam logic [2:0] ARX = `AMLI_A_RXDATA;
    localparam logic [2:0] AIS = `AMLI_A_ISTAT;
    localparam logic [2:0] AIC = `AMLI_A_ICTL;
    localparam logic [2:0] ATX = `AMLI_A_TXDATA;
    localparam logic [2:0] AOS = `AMLI_A_OSTAT;
    localparam logic [2:0] AOC = `AMLI_A_OCTL;
    logic        clk;
    logic        rstn;
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr_s;
    logic        rd_s;
    logic        car;
    logic [15:0] rdata;
    logic        txd;
    logic        con;
    logic        rts;
    logic        fsel;
    logic        rxd;
    logic        carrier;
    logic        dsr;
    logic        cts;
    int          cyc = 0;
    int          num_errors;
    int          samples_checked;

    amli_line_if #(.TIMEOUT_CYC(TO), .BIT_CYC(BC)) dut (
        .mclk_in      (clk),
        .rstn_in      (rstn),
        .addr_in      (addr),
        .wdata_in     (wdata),
        .wr_in        (wr_s),
        .rd_in        (rd_s),
        .rdata_out    (rdata),
        .rxd_in       (rxd),
        .carrier_in   (carrier),
        .dsr_in       (dsr),
        .cts_in       (cts),
        .txd_out      (txd),
        .connect_out  (con),
        .rts_out      (rts),
        .freq_sel_out (fsel)
    );

    amli_modem_model #(.BIT_CYC(BC)) modem (
        .mclk_in       (clk),
        .carrier_on_in (car),
        .connect_in    (con),
        .rts_in        (rts),
        .carrier_out   (carrier),
        .dsr_out       (dsr),
        .cts_out       (cts),
        .rxd_out       (rxd)
    );

    // Free running clock and a cycle count used to time frames.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    // Compare one value; X or Z never passes.
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Single place where the run ends.
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // A wait that ran out counts as a mismatch and closes the run.
    task automatic stuck(input string nm);
        num_errors++;
        $display("CHECK FAILED %s expected event seen timeout", nm);
        report_and_stop();
    endtask

    // Write cycle; one idle edge follows so strobes never merge.
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
    endtask

    // Read cycle; data stand only in the cycle after the strobe.
    task automatic rchk(input logic [2:0] a, input logic [15:0] exp, input string nm);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk(nm, rdata, exp);
    endtask

    // Expected frame bits: masked data with the even parity bit on top.
    function automatic logic [11:0] fr(input logic [7:0] d, input int n, input logic p);
        logic [7:0] m;
        m = 8'((1 << n) - 1);
        return {4'h0, d & m} | (12'(p & ^(d & m)) << n);
    endfunction

    // Capture one transmitted frame at mid bit, checking start and first stop.
    task automatic grab(input int n, output logic [11:0] v, output int t0);
        int k;
        k = 0;
        v = '0;
        do begin
            @(negedge clk);
            k++;
            if (k > 600) stuck("frame start");
        end while (txd !== 1'b0);
        t0 = cyc;
        repeat (BC / 2) @(negedge clk);
        chk("start bit", 16'(txd), 16'h0000);
        for (int i = 0; i < n; i++) begin
            repeat (BC) @(negedge clk);
            v[i] = txd;
        end
        repeat (BC) @(negedge clk);
        chk("stop bit", 16'(txd), 16'h0001);
    endtask

    // Bounded wait for send request to reach a level.
    task automatic wait_rts(input logic lv);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
            if (k > 12) stuck("send request");
        end while (rts !== lv);
    endtask

    // Idle values after reset; control words are write-only.
    task automatic t_reset();
        repeat (6) @(posedge clk);
        rchk(AIS, 16'h3800, "input status"); // Modem lines absent.
        rchk(AOS, 16'h3808, "output status"); // Buffer free, idle.
        rchk(AIC, 16'h0000, "control read");
        rchk(3'h1, 16'h0000, "unmapped read");
        $display("reset test done");
    endtask

    // Connect is gated by control bit 1; full duplex request follows it.
    task automatic t_connect();
        wr(AIC, 16'h0084);
        repeat (6) @(negedge clk);
        chk("gated connect", 16'(con), 16'h0000); // Still off line.
        wr(AIC, 16'h0486);
        repeat (6) @(negedge clk);
        chk("connect", 16'(con), 16'h0001); // On line.
        chk("full duplex request", 16'(rts), 16'h0001); // Tracks connect.
        chk("frequency select", 16'(fsel), 16'h0001); // Calling side.
        rchk(AIS, 16'h0C06, "connected status"); // Echo and lines.
        $display("connect test done");
    endtask

    // Every length code, two parity and stop settings, looped back in test mode.
    task automatic t_frames();
        logic [11:0] v;
        logic        par;
        logic        one;
        int          n;
        int          t0;
        int          t1;
        for (int c = 0; c < 4; c++) begin
            n   = 8 - c;
            par = (c == 1 || c == 2);
            one = c[1];
            wr(AIC, 16'h008E | 16'(c) << 11 | {1'b0, par, one, 13'h0});
            wr(AOC, 16'h0005);
            wr(ATX, 16'h00A5);
            wr(ATX, 16'h003C);
            grab(n + par, v, t0);
            chk("frame one", 16'(v), 16'(fr(8'hA5, n, par))); // Length, parity.
            grab(n + par, v, t1);
            chk("frame two", 16'(v), 16'(fr(8'h3C, n, par))); // Line still driven.
            chk("frame gap", 16'(t1 - t0), 16'((3 + n + par - one) * BC)); // Stops.
            repeat (2 * BC) @(negedge clk);
            rchk(AIS, 16'h089E, "overrun status"); // Second char overwrote.
            rchk(ARX, 16'(fr(8'h3C, n, 1'b0)), "looped char"); // Right justified.
        end
        rchk(AOS, 16'h0809, "output status idle"); // Enable echo, not busy.
        $display("frame test done");
    endtask

    // Carrier error summary, then channel clear.
    task automatic t_carrier();
        wr(AIC, 16'h0686);
        rchk(AIS, 16'h0F16, "carrier error"); // Missing and enabled.
        @(posedge clk);
        car <= 1'b1;
        repeat (8) @(negedge clk);
        rchk(AIS, 16'h0606, "carrier present"); // Error drops.
        wr(AIC, 16'h0010);
        repeat (6) @(negedge clk);
        chk("cleared connect", 16'(con), 16'h0000); // Off line.
        chk("cleared frequency", 16'(fsel), 16'h0000); // Back to called.
        rchk(AIS, 16'h3000, "status after clear"); // Enable gone.
        $display("carrier test done");
    endtask

    // Connect timeout without carrier, then with the timeout disabled.
    task automatic t_timeout();
        @(posedge clk);
        car <= 1'b0;
        wr(AIC, 16'h0006); // Software reactivates after the clear.
        repeat (TO - 40) @(negedge clk);
        chk("connect held", 16'(con), 16'h0001); // Too early to drop.
        repeat (60) @(negedge clk);
        chk("connect timed out", 16'(con), 16'h0000); // Dropped.
        wr(AIC, 16'h0000);
        wr(AIC, 16'h0086);
        repeat (TO + 60) @(negedge clk);
        chk("timeout disabled", 16'(con), 16'h0001); // Kept on.
        $display("timeout test done");
    endtask

    // Half duplex send request: carrier blocking, two-bit release, disable.
    task automatic t_half();
        logic [11:0] v;
        int          t0;
        wr(AIC, 16'h8086);
        @(posedge clk);
        car <= 1'b1;
        repeat (6) @(negedge clk); // Carrier must clear the pin filter first.
        wr(AOC, 16'h0004);
        repeat (10) @(negedge clk);
        chk("request blocked", 16'(rts), 16'h0000); // Carrier blocks.
        @(posedge clk);
        car <= 1'b0;
        wait_rts(1'b1); // Raised once carrier leaves.
        wr(ATX, 16'h0055);
        grab(8, v, t0);
        chk("half duplex frame", 16'(v), 16'h0055);
        rchk(AOS, 16'h880C, "busy in stop bits"); // Busy, buffer free.
        repeat (20) @(negedge clk);
        chk("request held", 16'(rts), 16'h0001); // Before two bit times.
        repeat (12) @(negedge clk);
        chk("request released", 16'(rts), 16'h0000); // After two bit times.
        wr(AIC, 16'h8186);
        wr(AOC, 16'h0004);
        wait_rts(1'b1);
        wr(ATX, 16'h00C3);
        grab(8, v, t0);
        repeat (60) @(negedge clk);
        chk("request kept", 16'(rts), 16'h0001); // No automatic release.
        wr(AOC, 16'h0000);
        repeat (6) @(negedge clk);
        chk("deactivated request", 16'(rts), 16'h0000); // Dropped by write.
        chk("deactivated connect", 16'(con), 16'h0000); // Connect too.
        $display("half duplex test done");
    endtask

    // Receiver errors from the modem: bad parity, then a missing stop bit.
    task automatic t_rxerr();
        wr(AIC, 16'h4086);
        modem.send_frame(12'h001, 9, 1'b1);
        rchk(AIS, 16'h385E, "parity error"); // Odd parity flagged.
        rchk(ARX, 16'h0001, "char one"); // Parity removed.
        modem.send_frame(12'h102, 9, 1'b0);
        rchk(AIS, 16'h383E, "framing error"); // Stop missing.
        rchk(ARX, 16'h0002, "char two"); // Right justified.
        $display("receiver error test done");
    endtask

    // Main sequence: reset for five cycles, then each scenario in turn.
    initial begin
        num_errors = 0;
        samples_checked = 0;
        rstn = 1'b0;
        addr = 3'h0;
        wdata = 16'h0000;
        wr_s = 1'b0;
        rd_s = 1'b0;
        car = 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_connect();
        t_frames();
        t_carrier();
        t_timeout();
        t_half();
        t_rxerr();
        report_and_stop();
    end
endmodule
`default_nettype wire
